// file: rtl/add_carry_unit.sv
// What this block does
// - Add-with-carry writes destination plus source plus carry flag back.
// - Plain add writes destination plus source, no carry-in.
// - Immediates are sign-extended to destination width before adding.
// - Both adds update overflow, sign, zero, nibble, carry, parity flags.
// - Overflow flags signed overflow; carry flags unsigned carry-out.
// - Sign flag takes the result's most significant bit.
// - Opcodes 14/15 add-with-carry immediate to accumulator, sized.
// - Group 80/81/83 with reg field 2 decode as add-with-carry.
// - Opcodes 10-13 register forms of add-with-carry; even is byte.
// - Plain add: 04/05, group reg field 0, and 00-03.
// - Protected: write into non-writable segment gives GP fault, code 0.
// - Segment limit overrun gives GP fault; code 0 outside real mode.
// - Protected: null data selector used gives GP fault, code 0.
// - Stack limit overrun gives stack fault; code 0 unless real mode.
// - Protected and v86: failed translation gives page fault with code.
// - Protected: unaligned with checking on faults only at privilege 3.
// - V86: unaligned with checking on faults, code 0, any privilege.
// - Real mode raises only limit faults, no page or alignment faults.
//
// The implementer's own choices: the APB interface to the registers and the placing of the registers.
module add_carry_unit (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Interrupt
  output logic irq,
  // Destination write-back
  output logic dest_wr,
  output logic dest_mem,
  output logic [31:0] dest_data,
  output logic op_done
);

  // ****************************************************************
  // State
  // ****************************************************************
  add_carry_pkg::state_t state_q;
  logic [31:0] opcode_q;
  logic [31:0] dest_q;
  logic [31:0] src_q;
  add_carry_pkg::mem_ctx_t ctx_q;
  logic [31:0] pf_code_q;
  add_carry_pkg::flags_t flags_q;
  logic [31:0] result_q;
  add_carry_pkg::fault_t fault_q;
  logic [31:0] err_code_q;
  logic [add_carry_pkg::EVT_W-1:0] irq_status_q;
  logic [add_carry_pkg::EVT_W-1:0] irq_enable_q;
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  logic irq_q;
  logic dest_wr_q;
  logic dest_mem_q;
  logic [31:0] dest_data_q;
  logic op_done_q;

  // ****************************************************************
  // APB decode
  // ****************************************************************
  logic access;
  logic wr_en;
  logic mapped;
  logic [31:0] rd_data;
  logic exec_req;
  logic [add_carry_pkg::EVT_W-1:0] irq_clr;

  assign access = psel && penable && pready_q;
  assign wr_en = access && pwrite && mapped;
  assign exec_req = wr_en && (paddr == add_carry_pkg::OFS_CMD) &&
                    pwdata[add_carry_pkg::CMD_EXEC_BIT];
  assign irq_clr = (wr_en && paddr == add_carry_pkg::OFS_IRQ_CLEAR) ?
                   pwdata[add_carry_pkg::EVT_W-1:0] :
                   add_carry_pkg::RST_EVT;

  always_comb begin
    mapped = 1'b1;
    rd_data = add_carry_pkg::RST_WORD;
    unique case (paddr)
      add_carry_pkg::OFS_OPCODE: rd_data = opcode_q;
      add_carry_pkg::OFS_DEST: rd_data = dest_q;
      add_carry_pkg::OFS_SRC: rd_data = src_q;
      add_carry_pkg::OFS_MEM_CTX: rd_data = 32'(ctx_q);
      add_carry_pkg::OFS_PF_CODE: rd_data = pf_code_q;
      add_carry_pkg::OFS_FLAGS: rd_data = 32'(flags_q);
      add_carry_pkg::OFS_RESULT: rd_data = result_q;
      add_carry_pkg::OFS_FAULT: rd_data = 32'(fault_q);
      add_carry_pkg::OFS_ERR_CODE: rd_data = err_code_q;
      add_carry_pkg::OFS_IRQ_STATUS: rd_data = 32'(irq_status_q);
      add_carry_pkg::OFS_IRQ_ENABLE: rd_data = 32'(irq_enable_q);
      add_carry_pkg::OFS_IRQ_CLEAR: rd_data = add_carry_pkg::RST_WORD;
      add_carry_pkg::OFS_CMD: rd_data = add_carry_pkg::RST_WORD;
      default: mapped = 1'b0;
    endcase
  end

  // One wait state: answer comes in the second access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= add_carry_pkg::RST_WORD;
    end else begin
      pready_q <= psel && penable && !pready_q;
      pslverr_q <= psel && penable && !pready_q && !mapped;
      if (psel && penable && !pready_q && !pwrite) begin
        prdata_q <= rd_data;
      end
    end
  end

  // ****************************************************************
  // Software-written operand and interrupt-enable registers
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      opcode_q <= add_carry_pkg::RST_WORD;
      dest_q <= add_carry_pkg::RST_WORD;
      src_q <= add_carry_pkg::RST_WORD;
      ctx_q <= '0;
      pf_code_q <= add_carry_pkg::RST_WORD;
      irq_enable_q <= add_carry_pkg::RST_EVT;
    end else if (wr_en) begin
      unique case (paddr)
        add_carry_pkg::OFS_OPCODE: opcode_q <= pwdata;
        add_carry_pkg::OFS_DEST: dest_q <= pwdata;
        add_carry_pkg::OFS_SRC: src_q <= pwdata;
        add_carry_pkg::OFS_MEM_CTX:
          ctx_q <= add_carry_pkg::mem_ctx_t'(
                     pwdata[add_carry_pkg::CTX_W-1:0]);
        add_carry_pkg::OFS_PF_CODE: pf_code_q <= pwdata;
        add_carry_pkg::OFS_IRQ_ENABLE:
          irq_enable_q <= pwdata[add_carry_pkg::EVT_W-1:0];
        default: ;
      endcase
    end
  end

  // ****************************************************************
  // Opcode decode
  // ****************************************************************
  logic [7:0] opc;
  logic [2:0] regf;
  logic valid;
  logic is_adc;
  logic rm_dest;
  logic uses_rm;
  logic imm_sx8;
  logic imm_full;
  add_carry_pkg::width_t width;

  assign opc = opcode_q[add_carry_pkg::OPC_LSB +: 8];
  assign regf = opcode_q[add_carry_pkg::REGF_LSB +: 3];

  always_comb begin
    valid = 1'b0;
    is_adc = 1'b0;
    rm_dest = 1'b0;
    uses_rm = 1'b0;
    imm_sx8 = 1'b0;
    imm_full = 1'b0;
    width = opcode_q[add_carry_pkg::OPSIZE32_BIT] ?
            add_carry_pkg::W32 : add_carry_pkg::W16;
    if ((opc[7:3] == add_carry_pkg::OPC_ADD_ROW ||
         opc[7:3] == add_carry_pkg::OPC_ADC_ROW) &&
        opc[2:0] <= add_carry_pkg::OPC_LAST_FORM) begin
      valid = 1'b1;
      is_adc = (opc[7:3] == add_carry_pkg::OPC_ADC_ROW);
      if (!opc[0]) begin
        width = add_carry_pkg::W8;
      end
      rm_dest = (opc[2:1] == add_carry_pkg::FORM_RM_DEST);
      uses_rm = (opc[2:1] != add_carry_pkg::FORM_ACC_IMM);
      imm_full = (opc[2:1] == add_carry_pkg::FORM_ACC_IMM) && opc[0];
    end else if (opc == add_carry_pkg::OPC_GRP_IMM8 ||
                 opc == add_carry_pkg::OPC_GRP_IMMF ||
                 opc == add_carry_pkg::OPC_GRP_SX8) begin
      valid = (regf == add_carry_pkg::GRP_ADD) ||
              (regf == add_carry_pkg::GRP_ADC);
      is_adc = (regf == add_carry_pkg::GRP_ADC);
      rm_dest = 1'b1;
      uses_rm = 1'b1;
      if (opc == add_carry_pkg::OPC_GRP_IMM8) begin
        width = add_carry_pkg::W8;
      end
      imm_sx8 = (opc == add_carry_pkg::OPC_GRP_SX8);
      imm_full = (opc == add_carry_pkg::OPC_GRP_IMMF);
    end
  end

  // ****************************************************************
  // Adder and flags
  // ****************************************************************
  logic [31:0] mask;
  logic [31:0] src_ext;
  logic [31:0] a;
  logic [31:0] b;
  logic cin;
  logic [32:0] sum;
  logic [31:0] res;
  logic res_msb;
  logic a_msb;
  logic b_msb;
  add_carry_pkg::flags_t flags_d;

  always_comb begin
    mask = 32'hffff_ffff;
    src_ext = src_q;
    unique case (width)
      add_carry_pkg::W8: mask = 32'h0000_00ff;
      add_carry_pkg::W16: mask = 32'h0000_ffff;
      add_carry_pkg::W32: mask = 32'hffff_ffff;
      default: mask = 32'hffff_ffff;
    endcase
    if (imm_sx8) begin
      src_ext = {{24{src_q[7]}}, src_q[7:0]};
    end else if (imm_full && width == add_carry_pkg::W16) begin
      src_ext = {{16{src_q[15]}}, src_q[15:0]};
    end
  end

  assign a = dest_q & mask;
  assign b = src_ext & mask;
  assign cin = is_adc ? flags_q.carry_flag : 1'b0;
  assign sum = {1'b0, a} + {1'b0, b} + {32'h0000_0000, cin};
  assign res = sum[31:0] & mask;

  always_comb begin
    flags_d = flags_q;
    unique case (width)
      add_carry_pkg::W8: begin
        res_msb = res[7];
        a_msb = a[7];
        b_msb = b[7];
        flags_d.carry_flag = sum[8];
      end
      add_carry_pkg::W16: begin
        res_msb = res[15];
        a_msb = a[15];
        b_msb = b[15];
        flags_d.carry_flag = sum[16];
      end
      default: begin
        res_msb = res[31];
        a_msb = a[31];
        b_msb = b[31];
        flags_d.carry_flag = sum[32];
      end
    endcase
    flags_d.sign_flag = res_msb;
    flags_d.signed_overflow_flag = (a_msb == b_msb) &&
                                   (res_msb != a_msb);
    flags_d.zero_result_flag = (res == 32'h0000_0000);
    flags_d.nibble_carry_flag = a[4] ^ b[4] ^ sum[4];
    flags_d.parity_flag = ~^res[7:0];
  end

  // ****************************************************************
  // Memory operand checks
  // ****************************************************************
  logic mem_op;
  add_carry_pkg::fault_t fault_d;
  logic [31:0] err_d;

  assign mem_op = uses_rm && opcode_q[add_carry_pkg::MODRM_MEM_BIT];

  // Checks ordered segment, then paging, then alignment
  always_comb begin
    fault_d = '0;
    err_d = add_carry_pkg::RST_WORD;
    if (mem_op) begin
      unique case (ctx_q.mode)
        add_carry_pkg::MODE_REAL: begin
          if (ctx_q.over_limit) begin
            fault_d.valid = 1'b1;
            fault_d.kind = ctx_q.stack_seg ? add_carry_pkg::FK_SS :
                           add_carry_pkg::FK_GP;
          end
        end
        add_carry_pkg::MODE_V86: begin
          if (ctx_q.over_limit) begin
            fault_d.valid = 1'b1;
            fault_d.has_code = 1'b1;
            fault_d.kind = ctx_q.stack_seg ? add_carry_pkg::FK_SS :
                           add_carry_pkg::FK_GP;
          end else if (ctx_q.page_fail) begin
            fault_d = '{1'b1, 1'b1, add_carry_pkg::FK_PF};
            err_d = pf_code_q;
          end else if (ctx_q.align_en && ctx_q.unaligned) begin
            fault_d = '{1'b1, 1'b1, add_carry_pkg::FK_AC};
          end
        end
        // Reserved mode code is checked as protected, the strictest
        default: begin
          if (rm_dest && !ctx_q.seg_writable) begin
            fault_d = '{1'b1, 1'b1, add_carry_pkg::FK_GP};
          end else if (ctx_q.null_sel && !ctx_q.stack_seg) begin
            fault_d = '{1'b1, 1'b1, add_carry_pkg::FK_GP};
          end else if (ctx_q.over_limit) begin
            fault_d.valid = 1'b1;
            fault_d.has_code = 1'b1;
            fault_d.kind = ctx_q.stack_seg ? add_carry_pkg::FK_SS :
                           add_carry_pkg::FK_GP;
          end else if (ctx_q.page_fail) begin
            fault_d = '{1'b1, 1'b1, add_carry_pkg::FK_PF};
            err_d = pf_code_q;
          end else if (ctx_q.align_en && ctx_q.unaligned &&
                       ctx_q.cpl == add_carry_pkg::USER_PRIV) begin
            fault_d = '{1'b1, 1'b1, add_carry_pkg::FK_AC};
          end
        end
      endcase
    end
  end

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= add_carry_pkg::ST_IDLE;
    end else begin
      unique case (state_q)
        add_carry_pkg::ST_IDLE: begin
          if (exec_req) begin
            state_q <= add_carry_pkg::ST_EXEC;
          end
        end
        add_carry_pkg::ST_EXEC: state_q <= add_carry_pkg::ST_IDLE;
      endcase
    end
  end

  logic exec;
  logic commit;
  assign exec = (state_q == add_carry_pkg::ST_EXEC);
  assign commit = exec && valid && !fault_d.valid;

  // Hardware update beats a same-cycle software write of the flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_q <= '0;
    end else if (commit) begin
      flags_q <= flags_d;
    end else if (wr_en && paddr == add_carry_pkg::OFS_FLAGS) begin
      flags_q <= add_carry_pkg::flags_t'(
                   pwdata[add_carry_pkg::FLAGS_W-1:0]);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result_q <= add_carry_pkg::RST_WORD;
      fault_q <= '0;
      err_code_q <= add_carry_pkg::RST_WORD;
    end else if (exec) begin
      fault_q <= fault_d;
      err_code_q <= err_d;
      if (commit) begin
        result_q <= res;
      end
    end
  end

  // Faulted or undecodable operations never reach the destination
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dest_wr_q <= 1'b0;
      dest_mem_q <= 1'b0;
      dest_data_q <= add_carry_pkg::RST_WORD;
      op_done_q <= 1'b0;
    end else begin
      dest_wr_q <= commit;
      op_done_q <= exec;
      if (commit) begin
        dest_mem_q <= mem_op && rm_dest;
        dest_data_q <= res;
      end
    end
  end

  // ****************************************************************
  // Interrupts
  // ****************************************************************
  logic [add_carry_pkg::EVT_W-1:0] evt;
  assign evt = {exec && !valid, exec && valid && fault_d.valid, exec};

  // Set wins over a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status_q <= add_carry_pkg::RST_EVT;
      irq_q <= 1'b0;
    end else begin
      irq_status_q <= (irq_status_q & ~irq_clr) | evt;
      irq_q <= |(((irq_status_q & ~irq_clr) | evt) & irq_enable_q);
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign irq = irq_q;
  assign dest_wr = dest_wr_q;
  assign dest_mem = dest_mem_q;
  assign dest_data = dest_data_q;
  assign op_done = op_done_q;

endmodule

// file: rtl/add_carry_pkg.sv
package add_carry_pkg;

  // ****************************************************************
  // Register map (byte offsets on the APB)
  // ****************************************************************
  localparam logic [7:0] OFS_OPCODE = 8'h00;
  localparam logic [7:0] OFS_DEST = 8'h04;
  localparam logic [7:0] OFS_SRC = 8'h08;
  localparam logic [7:0] OFS_MEM_CTX = 8'h0c;
  localparam logic [7:0] OFS_PF_CODE = 8'h10;
  localparam logic [7:0] OFS_FLAGS = 8'h14;
  localparam logic [7:0] OFS_RESULT = 8'h18;
  localparam logic [7:0] OFS_FAULT = 8'h1c;
  localparam logic [7:0] OFS_ERR_CODE = 8'h20;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h24;
  localparam logic [7:0] OFS_IRQ_ENABLE = 8'h28;
  localparam logic [7:0] OFS_IRQ_CLEAR = 8'h2c;
  localparam logic [7:0] OFS_CMD = 8'h30;

  // ****************************************************************
  // Field positions and widths
  // ****************************************************************
  localparam int OPC_LSB = 0;
  localparam int REGF_LSB = 8;
  localparam int MODRM_MEM_BIT = 11;
  localparam int OPSIZE32_BIT = 12;
  localparam int CMD_EXEC_BIT = 0;
  localparam int CTX_W = 11;
  localparam int FLAGS_W = 6;
  localparam int EVT_W = 3;
  localparam int EVT_DONE = 0;
  localparam int EVT_FAULT = 1;
  localparam int EVT_DECODE_ERR = 2;

  // ****************************************************************
  // Opcodes and group selectors
  // ****************************************************************
  localparam logic [4:0] OPC_ADD_ROW = 5'h00;
  localparam logic [4:0] OPC_ADC_ROW = 5'h02;
  localparam logic [2:0] OPC_LAST_FORM = 3'h5;
  localparam logic [7:0] OPC_GRP_IMM8 = 8'h80;
  localparam logic [7:0] OPC_GRP_IMMF = 8'h81;
  localparam logic [7:0] OPC_GRP_SX8 = 8'h83;
  localparam logic [2:0] GRP_ADD = 3'h0;
  localparam logic [2:0] GRP_ADC = 3'h2;
  localparam logic [1:0] FORM_RM_DEST = 2'h0;
  localparam logic [1:0] FORM_REG_DEST = 2'h1;
  localparam logic [1:0] FORM_ACC_IMM = 2'h2;
  localparam logic [1:0] USER_PRIV = 2'h3;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [EVT_W-1:0] RST_EVT = 3'h0;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {
    MODE_REAL = 2'h0,
    MODE_PROT = 2'h1,
    MODE_V86 = 2'h2,
    MODE_RSVD = 2'h3
  } cpu_mode_t;

  typedef enum logic [1:0] {
    W8 = 2'h0,
    W16 = 2'h1,
    W32 = 2'h2
  } width_t;

  typedef enum logic [2:0] {
    FK_NONE = 3'h0,
    FK_GP = 3'h1,
    FK_SS = 3'h2,
    FK_PF = 3'h3,
    FK_AC = 3'h4
  } fault_kind_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_EXEC = 2'b10
  } state_t;

  // Memory-operand context, low bits of the context register
  typedef struct packed {
    logic [1:0] cpl;
    logic align_en;
    logic unaligned;
    logic page_fail;
    logic null_sel;
    logic stack_seg;
    logic over_limit;
    logic seg_writable;
    cpu_mode_t mode;
  } mem_ctx_t;

  // Status flags, carry in bit 0
  typedef struct packed {
    logic signed_overflow_flag;
    logic sign_flag;
    logic zero_result_flag;
    logic nibble_carry_flag;
    logic parity_flag;
    logic carry_flag;
  } flags_t;

  typedef struct packed {
    logic valid;
    logic has_code;
    fault_kind_t kind;
  } fault_t;

endpackage

// file: tb/add_carry_unit_checker.sv
module add_carry_unit_checker (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Interrupt and write-back
  input wire logic irq,
  input wire logic dest_wr,
  input wire logic dest_mem,
  input wire logic [31:0] dest_data,
  input wire logic op_done
);
  logic wr_go;
  logic cmd_go;
  logic [31:0] opc_q;
  logic [31:0] dst_q;
  logic [31:0] src_q;

  assign wr_go = psel && penable && pready && pwrite;
  assign cmd_go = wr_go && paddr == add_carry_pkg::OFS_CMD && pwdata[0];

  // Shadows; APB spacing keeps them steady through an execution
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      opc_q <= 32'h0;
      dst_q <= 32'h0;
      src_q <= 32'h0;
    end else if (wr_go) begin
      if (paddr == add_carry_pkg::OFS_OPCODE) begin
        opc_q <= pwdata;
      end
      if (paddr == add_carry_pkg::OFS_DEST) begin
        dst_q <= pwdata;
      end
      if (paddr == add_carry_pkg::OFS_SRC) begin
        src_q <= pwdata;
      end
    end
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  AST_CMD_DONE: assert property (cmd_go |-> ##2 op_done)
    else $error("no op_done two cycles after execute");
  AST_DONE_CAUSE: assert property (op_done |-> $past(cmd_go, 2))
    else $error("op_done without execute command");
  AST_WB_AT_DONE: assert property (dest_wr |-> op_done)
    else $error("write-back outside completion");
  AST_WB_HOLD: assert property (
    !dest_wr |-> $stable(dest_data) && $stable(dest_mem))
    else $error("destination changed without write-back");
  AST_BYTE_HI: assert property (
    dest_wr && !opc_q[0] |-> dest_data[31:8] == 24'h0)
    else $error("byte result wider than a byte");
  AST_WORD_HI: assert property (
    dest_wr && opc_q[0] && !opc_q[12] |-> dest_data[31:16] == 16'h0)
    else $error("word result wider than a word");
  AST_ADD_BYTE: assert property (
    dest_wr && opc_q[7:0] == 8'h00
    |-> dest_data == {24'h0, dst_q[7:0] + src_q[7:0]})
    else $error("byte add result wrong");
  AST_REG_DEST: assert property (
    dest_wr && !opc_q[11] |-> !dest_mem)
    else $error("register operand written to memory");
  AST_ERR_READY: assert property (pslverr |-> pready)
    else $error("error without ready");
  AST_WAIT: assert property (psel && !penable |=> !pready ##1 pready)
    else $error("ready not on second access cycle");
endmodule

bind add_carry_unit add_carry_unit_checker checker_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .irq(irq), .dest_wr(dest_wr),
  .dest_mem(dest_mem), .dest_data(dest_data), .op_done(op_done));

// file: tb/dest_sink_model.sv
module dest_sink_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Write-back from the unit
  input wire logic dest_wr,
  input wire logic dest_mem,
  input wire logic [31:0] dest_data,
  // Captured destinations
  output logic [31:0] reg_q,
  output logic [31:0] mem_q,
  output logic [15:0] count_q
);
  // Register file and memory take a write-back in its own cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reg_q <= 32'h0;
      mem_q <= 32'h0;
      count_q <= 16'h0;
    end else if (dest_wr) begin
      if (dest_mem) begin
        mem_q <= dest_data;
      end else begin
        reg_q <= dest_data;
      end
      count_q <= count_q + 16'h1;
    end
  end
endmodule

// file: tb/add_carry_unit_tb.sv
module add_carry_unit_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk, presetn, psel, penable, pwrite, err;
  logic pready, pslverr, irq, dest_wr, dest_mem, op_done;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, dest_data, rd, sink_reg, sink_mem;
  logic [15:0] sink_cnt;
  int failures = 0;
  int checks = 0;

  add_carry_unit dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .dest_wr(dest_wr), .dest_mem(dest_mem), .dest_data(dest_data),
    .op_done(op_done));
  dest_sink_model sink (.pclk(pclk), .presetn(presetn), .dest_wr(dest_wr),
    .dest_mem(dest_mem), .dest_data(dest_data), .reg_q(sink_reg),
    .mem_q(sink_mem), .count_q(sink_cnt));

  initial begin
    pclk = 1'h0;
    forever #10 pclk = ~pclk;
  end

  // ********
  // Shared tasks
  // ********
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    if (n >= 20) check(32'h1, 32'h0);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic run_op(input logic [31:0] opc, dst, src, ctx, flg);
    int n;
    n = 0;
    apb(1'h1, add_carry_pkg::OFS_OPCODE, opc);
    apb(1'h1, add_carry_pkg::OFS_DEST, dst);
    apb(1'h1, add_carry_pkg::OFS_SRC, src);
    apb(1'h1, add_carry_pkg::OFS_MEM_CTX, ctx);
    apb(1'h1, add_carry_pkg::OFS_FLAGS, flg);
    apb(1'h1, add_carry_pkg::OFS_CMD, 32'h1);
    do begin
      @(posedge pclk);
      n++;
    end while (op_done !== 1'h1 && n < 20);
    if (n >= 20) check(32'h1, 32'h0);
    @(negedge pclk);
  endtask

  // Result in [31:0], flags in [37:32]
  function automatic logic [37:0] ref_add(input logic [31:0] opc, d, s,
    input logic cin);
    longint m, r, x, y;
    int n;
    logic [5:0] f;
    n = !opc[0] ? 8 : opc[12] ? 32 : 16;
    m = (64'h1 << n) - 64'h1;
    x = d & m;
    y = (opc[7:0] == 8'h83) ? {{24{s[7]}}, s[7:0]} & m : s & m;
    r = x + y + cin;
    f[0] = r[n];
    r = r & m;
    f[1] = ~^r[7:0];
    f[2] = x[4] ^ y[4] ^ r[4];
    f[3] = r == 0;
    f[4] = r[n-1];
    f[5] = x[n-1] == y[n-1] && r[n-1] != x[n-1];
    return {f, r[31:0]};
  endfunction

  // ********
  // Scenarios
  // ********
  task automatic t_regs();
    apb(1'h1, add_carry_pkg::OFS_RESULT, 32'hffff_ffff);
    apb(1'h0, add_carry_pkg::OFS_RESULT, 32'h0);
    check(rd, add_carry_pkg::RST_WORD);
    apb(1'h0, add_carry_pkg::OFS_IRQ_STATUS, 32'h0);
    check(rd, add_carry_pkg::RST_WORD);
    apb(1'h0, 8'h40, 32'h0);
    check({err, rd}, {1'h1, 32'h0});
    apb(1'h0, 8'h06, 32'h0);
    check({31'h0, err}, 32'h1);
    $display("test regs done");
  endtask

  task automatic t_arith();
    logic [31:0] dv [3] = '{32'h7fff_ff7f, 32'h7fff_ffff, 32'h0000_7fff};
    logic [31:0] sv [3] = '{32'h8000_0081, 32'h0000_0001, 32'h0000_0001};
    logic [11:0] ops [18] = '{12'h000, 12'h001, 12'h002, 12'h003, 12'h004,
      12'h005, 12'h080, 12'h081, 12'h083, 12'h010, 12'h011, 12'h012,
      12'h013, 12'h014, 12'h015, 12'h280, 12'h281, 12'h283};
    logic [37:0] e;
    logic [31:0] opc;
    for (int i = 0; i < 36; i++) begin
      for (int k = 0; k < 3; k++) begin
        opc = {19'h0, i[0], ops[i / 2]};
        e = ref_add(opc, dv[k], sv[k], i >= 18);
        // Carry preset so a plain add that uses it shows up
        run_op(opc, dv[k], sv[k], 32'h0, 32'h3f);
        check(sink_reg, e[31:0]);
        check(dest_data, e[31:0]);
        apb(1'h0, add_carry_pkg::OFS_FLAGS, 32'h0);
        check(rd, {26'h0, e[37:32]});
      end
    end
    $display("test arith done");
  endtask

  task automatic t_fault();
    logic [31:0] cx [12] = '{32'h001, 32'h025, 32'h00d, 32'h01d, 32'h045,
      32'h785, 32'h185, 32'h186, 32'h046, 32'h008, 32'h018, 32'h7c0};
    logic [7:0] fk [12] = '{8'h19, 8'h19, 8'h19, 8'h1a, 8'h1b, 8'h1c,
      8'h00, 8'h1c, 8'h1b, 8'h11, 8'h12, 8'h00};
    logic [15:0] n;
    for (int i = 0; i < 12; i++) begin
      n = sink_cnt;
      apb(1'h1, add_carry_pkg::OFS_PF_CODE, 32'h0000_0a5c);
      run_op(32'h800, 32'h10, 32'h20, cx[i], 32'h0);
      apb(1'h0, add_carry_pkg::OFS_FAULT, 32'h0);
      check(rd, {24'h0, fk[i]});
      check({29'h0, rd[2:0]}, {29'h0, fk[i][2:0]});
      apb(1'h0, add_carry_pkg::OFS_ERR_CODE, 32'h0);
      check(rd, fk[i] == 8'h1b ? 32'h0a5c : 32'h0);
      check({16'h0, sink_cnt - n}, {31'h0, fk[i] == 8'h0});
      apb(1'h0, add_carry_pkg::OFS_FLAGS, 32'h0);
      if (fk[i] == 8'h0) check(sink_mem, 32'h30);
      else check(rd, 32'h0);
    end
    $display("test fault done");
  endtask

  task automatic t_irq();
    logic [15:0] n;
    n = sink_cnt;
    apb(1'h1, add_carry_pkg::OFS_IRQ_CLEAR, 32'h7);
    apb(1'h1, add_carry_pkg::OFS_IRQ_ENABLE, 32'h4);
    run_op(32'h180, 32'h1, 32'h1, 32'h0, 32'h0);
    check({31'h0, irq}, 32'h1);
    check({16'h0, sink_cnt}, {16'h0, n});
    apb(1'h1, add_carry_pkg::OFS_IRQ_ENABLE, 32'h0);
    apb(1'h0, add_carry_pkg::OFS_IRQ_STATUS, 32'h0);
    check({rd[2], irq}, 2'h2);
    apb(1'h1, add_carry_pkg::OFS_IRQ_ENABLE, 32'h4);
    apb(1'h1, add_carry_pkg::OFS_IRQ_CLEAR, 32'h4);
    apb(1'h0, add_carry_pkg::OFS_IRQ_STATUS, 32'h0);
    check({rd[2], irq}, 2'h0);
    $display("test irq done");
  endtask

  task automatic give_verdict();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge pclk);
    failures++;
    $display("mismatch at %0t: watchdog expired", $time);
    give_verdict();
  end

  initial begin
    presetn = 1'h0;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    repeat (8) @(posedge pclk);
    presetn <= 1'h1;
    t_regs();
    t_arith();
    t_fault();
    t_irq();
    give_verdict();
  end
endmodule
